//--- tdu_pkg.sv
// Constants shared by the timer-driven half-duplex serial block
// Functional notes
// - Frame is start, eight data LSB first, stop
// - Programmable rate, at most 19200 bits/s; the code does not limit the rate and MAX_BAUD is unused
// - Never transmit and receive at once
// - Each bit handled on a timer period event
// - Channel 4 paces receive, channel 5 transmit
// - Transmit start enables event, runs counter, stops
// - Transmit via channel pin, receive via edge input
// - Start needs falling edge then mid-bit low
// - Confirmed start samples eight data bits mid-bit
// - Three-bit prescale select, eight coarse ratios
// - Event passes full enable and mask chain
// - Period interrupt enable raises event per period
// - Halt bit stops channel during doze
// - Forced interrupt bit raises event immediately
// - Immediate update bit loads period at once
// - Pin data bit reflects or drives pin
// - Direction bit: one output, zero input
// - Output invert affects waveform mode only
// - Mode bit: zero general-purpose, one waveform
// - Counter run bit starts and stops counter
// - Prescale bits 2..0; 000 div 4, 001 div 8
// - Transmit line idles high, driven per bit
// - First receive period half, then full
package tdu_pkg;
  localparam int          CLK_HZ      = 10_000_000;
  localparam int          MAX_BAUD    = 19_200;
  localparam int          PER_W       = 10;
  localparam int          PRE_W       = 3;
  localparam logic [9:0]  DIV_BASE    = 10'h004;
  // Register byte addresses
  localparam logic [31:0] A_RX_CTRL   = 32'h1000_5020;
  localparam logic [31:0] A_RX_PER    = 32'h1000_5024;
  localparam logic [31:0] A_TX_CTRL   = 32'h1000_5028;
  localparam logic [31:0] A_TX_PER    = 32'h1000_502c;
  localparam logic [31:0] A_TX_DATA   = 32'h1000_5030;
  localparam logic [31:0] A_RX_DATA   = 32'h1000_5034;
  localparam logic [31:0] A_INT_CTRL  = 32'h1000_5038;
  localparam logic [31:0] A_INT_MASK  = 32'h1000_503c;
  // Channel control fields
  localparam int          CB_HALT     = 11;
  localparam int          CB_FORCE    = 10;
  localparam int          CB_PERIOD_INTERRUPT_ENABLE    = 9;
  localparam int          CB_LOAD     = 8;
  localparam int          CB_PIN      = 7;
  localparam int          CB_DIR      = 6;
  localparam int          CB_INV      = 5;
  localparam int          CB_MODE     = 4;
  localparam int          CB_RUN      = 3;
  localparam logic [15:0] CTRL_WMASK  = 16'h0fff;
  localparam int          WID_LSB     = 16;
  // Enable chain fields
  localparam int          IC_EE       = 0;
  localparam int          IC_IE       = 1;
  localparam int          IC_FE       = 2;
  localparam int          IC_EDGE     = 3;
  localparam int          SRC_TX      = 15;
  localparam int          SRC_RX      = 14;
  localparam int          SRC_EDGE    = 6;
  // Frame sequencing
  localparam logic [3:0]  TX_STOP_IDX = 4'h9;
  localparam logic [3:0]  TX_END_IDX  = 4'ha;
  localparam logic [2:0]  RX_LAST     = 3'h7;
endpackage

//--- tdu_chan.sv
// Interval timer channel with prescaler and period event
`timescale 1ns/1ps
`default_nettype none
module tdu_chan #(
  parameter int PER_W = tdu_pkg::PER_W,
  parameter int PRE_W = tdu_pkg::PRE_W
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             run,
  input  wire logic             freeze,
  input  wire logic [PRE_W-1:0] presc,
  input  wire logic [PER_W-1:0] period,
  input  wire logic [PER_W-1:0] width,
  input  wire logic             half_first,
  input  wire logic             load_now,
  output logic                  done,
  output logic                  wave
);
  logic [9:0]       pre;
  logic [9:0]       div;
  logic [PER_W-1:0] cnt;
  logic [PER_W-1:0] act_per;
  logic [PER_W-1:0] act_wid;
  logic             tick;
  logic             last;

  // Divide ratio 4 shifted by the select code
  assign div  = tdu_pkg::DIV_BASE << presc;
  assign tick = run && !freeze && (pre == div - 10'h001);
  assign last = (cnt >= act_per - PER_W'(1));

  // Prescaler, cleared while stopped, held while halted
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre <= '0;
    end else if (!run) begin
      pre <= '0;
    end else if (!freeze) begin
      pre <= tick ? '0 : pre + 10'h001;
    end
  end

  // Period counter and active period reload
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt     <= '0;
      act_per <= '0;
      act_wid <= '0;
    end else if (!run) begin
      cnt     <= '0;
      act_per <= half_first ? (period >> 1) : period;
      act_wid <= width;
    end else if (load_now) begin
      cnt     <= '0;
      act_per <= period;
      act_wid <= width;
    end else if (tick) begin
      if (last) begin
        cnt     <= '0;
        act_per <= period;
        act_wid <= width;
      end else begin
        cnt <= cnt + PER_W'(1);
      end
    end
  end

  // Period completion pulse and waveform level
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
      wave <= 1'b0;
    end else begin
      done <= tick && last;
      wave <= run && (cnt < act_wid);
    end
  end
endmodule
`default_nettype wire

//--- tdu_uart.sv
// Timer-paced half-duplex serial block with Wishbone registers
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module tdu_uart (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        doze,
  input  wire logic        tx_pin_i,
  output logic             tx_pin_o,
  output logic             tx_pin_oe,
  input  wire logic        rx_edge_i
);
  typedef enum logic {TX_IDLE, TX_RUN} tdu_tx_e;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} tdu_rx_e;

  logic [15:0] tx_ctrl;
  logic [15:0] rx_ctrl;
  logic [31:0] tx_per;
  logic [31:0] rx_per;
  logic [3:0]  int_ctrl;
  logic [31:0] int_mask;
  tdu_tx_e     tx_st;
  tdu_rx_e     rx_st;
  logic [3:0]  tx_idx;
  logic [7:0]  tx_sh;
  logic [7:0]  tx_hold;
  logic        hold_full;
  logic [2:0]  rx_cnt;
  logic [7:0]  rx_sh;
  logic [7:0]  rx_byte;
  logic        rx_full;
  logic        rx_s1;
  logic        rx_s2;
  logic        rx_prev;
  logic        tp_s1;
  logic        tp_s2;
  logic        acc;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        tx_done;
  logic        rx_done;
  logic        tx_wave;
  logic        tx_force;
  logic        rx_force;
  logic        tx_load;
  logic        rx_load;
  logic        tx_evt;
  logic        rx_evt;
  logic        edge_evt;
  logic        tx_start;
  logic        fall;
  logic [31:0] next_tx_ctrl;
  logic [31:0] next_rx_ctrl;

  // Byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  // Enable chain from a source down to the sequencer
  function automatic logic gate(input logic [3:0]  ic,
                                input logic [31:0] msk,
                                input int          src);
    return ic[tdu_pkg::IC_EE] &&
           ((ic[tdu_pkg::IC_IE] && msk[src]) ||
            (ic[tdu_pkg::IC_FE] && msk[16 + src]));
  endfunction

  // Bus strobes, one access per ack
  assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr  = acc && wb_we_i;
  assign rd  = acc && !wb_we_i;
  assign next_tx_ctrl = merge({16'h0000, tx_ctrl}, wb_dat_i, wb_sel_i);
  assign next_rx_ctrl = merge({16'h0000, rx_ctrl}, wb_dat_i, wb_sel_i);

  // One-shot control strobes from control writes
  assign tx_force = wr && (wb_adr_i == tdu_pkg::A_TX_CTRL) &&
                    next_tx_ctrl[tdu_pkg::CB_FORCE];
  assign rx_force = wr && (wb_adr_i == tdu_pkg::A_RX_CTRL) &&
                    next_rx_ctrl[tdu_pkg::CB_FORCE];
  assign tx_load  = wr && (wb_adr_i == tdu_pkg::A_TX_CTRL) &&
                    next_tx_ctrl[tdu_pkg::CB_LOAD];
  assign rx_load  = wr && (wb_adr_i == tdu_pkg::A_RX_CTRL) &&
                    next_rx_ctrl[tdu_pkg::CB_LOAD];

  // Gated per-bit events
  assign tx_evt   = gate(int_ctrl, int_mask, tdu_pkg::SRC_TX) &&
                    ((tx_done && tx_ctrl[tdu_pkg::CB_PERIOD_INTERRUPT_ENABLE]) || tx_force);
  assign rx_evt   = gate(int_ctrl, int_mask, tdu_pkg::SRC_RX) &&
                    ((rx_done && rx_ctrl[tdu_pkg::CB_PERIOD_INTERRUPT_ENABLE]) || rx_force);
  assign fall     = rx_prev && !rx_s2;
  assign edge_evt = fall && int_ctrl[tdu_pkg::IC_EDGE] &&
                    gate(int_ctrl, int_mask, tdu_pkg::SRC_EDGE);
  // Receive start wins a same-cycle tie so both never run at once
  assign tx_start = (tx_st == TX_IDLE) && (rx_st == RX_IDLE) && hold_full && !edge_evt;

  // Transmit interval timer, channel 5
  tdu_chan u_tx_chan (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .run        (tx_ctrl[tdu_pkg::CB_RUN]),
    .freeze     (doze && tx_ctrl[tdu_pkg::CB_HALT]),
    .presc      (tx_ctrl[tdu_pkg::PRE_W-1:0]),
    .period     (tx_per[tdu_pkg::PER_W-1:0]),
    .width      (tx_per[tdu_pkg::WID_LSB +: tdu_pkg::PER_W]),
    .half_first (1'b0),
    .load_now   (tx_load),
    .done       (tx_done),
    .wave       (tx_wave)
  );

  // Receive interval timer, channel 4, half first period
  tdu_chan u_rx_chan (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .run        (rx_ctrl[tdu_pkg::CB_RUN]),
    .freeze     (doze && rx_ctrl[tdu_pkg::CB_HALT]),
    .presc      (rx_ctrl[tdu_pkg::PRE_W-1:0]),
    .period     (rx_per[tdu_pkg::PER_W-1:0]),
    .width      (rx_per[tdu_pkg::WID_LSB +: tdu_pkg::PER_W]),
    .half_first (1'b1),
    .load_now   (rx_load),
    .done       (rx_done),
    .wave       ()
  );

  // Pin synchronisers and edge history
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1   <= 1'b1;
      rx_s2   <= 1'b1;
      rx_prev <= 1'b1;
      tp_s1   <= 1'b1;
      tp_s2   <= 1'b1;
    end else begin
      rx_s1   <= rx_edge_i;
      rx_s2   <= rx_s1;
      rx_prev <= rx_s2;
      tp_s1   <= tx_pin_i;
      tp_s2   <= tp_s1;
    end
  end

  // Wishbone ack and read data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= acc;
      if (rd) begin
        wb_dat_o <= rdata;
      end
    end
  end

  // Read mux, unmapped reads zero
  always_comb begin
    rdata = '0;
    if (wb_adr_i == tdu_pkg::A_TX_CTRL) begin
      rdata[15:0] = tx_ctrl;
      if (!tx_ctrl[tdu_pkg::CB_MODE] && !tx_ctrl[tdu_pkg::CB_DIR]) begin
        rdata[tdu_pkg::CB_PIN] = tp_s2;
      end
    end else if (wb_adr_i == tdu_pkg::A_RX_CTRL) begin
      rdata[15:0] = rx_ctrl;
    end else if (wb_adr_i == tdu_pkg::A_TX_PER) begin
      rdata = tx_per;
    end else if (wb_adr_i == tdu_pkg::A_RX_PER) begin
      rdata = rx_per;
    end else if (wb_adr_i == tdu_pkg::A_TX_DATA) begin
      rdata[3:0] = {rx_full, rx_st != RX_IDLE, hold_full, tx_st == TX_RUN};
    end else if (wb_adr_i == tdu_pkg::A_RX_DATA) begin
      rdata[8:0] = {rx_full, rx_byte};
    end else if (wb_adr_i == tdu_pkg::A_INT_CTRL) begin
      rdata[3:0] = int_ctrl;
    end else if (wb_adr_i == tdu_pkg::A_INT_MASK) begin
      rdata = int_mask;
    end
  end

  // Period, width and enable chain registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_per   <= '0;
      rx_per   <= '0;
      int_ctrl <= '0;
      int_mask <= '0;
    end else if (wr) begin
      if (wb_adr_i == tdu_pkg::A_TX_PER) begin
        tx_per <= merge(tx_per, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == tdu_pkg::A_RX_PER) begin
        rx_per <= merge(rx_per, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == tdu_pkg::A_INT_CTRL) begin
        int_ctrl <= wb_sel_i[0] ? wb_dat_i[3:0] : int_ctrl;
      end else if (wb_adr_i == tdu_pkg::A_INT_MASK) begin
        int_mask <= merge(int_mask, wb_dat_i, wb_sel_i);
      end
    end
  end

  // Transmit control register, software then sequencer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ctrl <= '0;
    end else begin
      if (wr && wb_adr_i == tdu_pkg::A_TX_CTRL) begin
        tx_ctrl <= next_tx_ctrl[15:0] & tdu_pkg::CTRL_WMASK &
                   ~(16'h0001 << tdu_pkg::CB_FORCE) &
                   ~(16'h0001 << tdu_pkg::CB_LOAD);
      end
      if (tx_start) begin
        tx_ctrl[tdu_pkg::CB_PERIOD_INTERRUPT_ENABLE] <= 1'b1;
        tx_ctrl[tdu_pkg::CB_RUN]   <= 1'b1;
        tx_ctrl[tdu_pkg::CB_PIN]   <= 1'b1;
      end else if (tx_st == TX_RUN && tx_evt) begin
        if (tx_idx == '0) begin
          tx_ctrl[tdu_pkg::CB_PIN] <= 1'b0;
        end else if (tx_idx < tdu_pkg::TX_STOP_IDX) begin
          tx_ctrl[tdu_pkg::CB_PIN] <= tx_sh[0];
        end else if (tx_idx == tdu_pkg::TX_STOP_IDX) begin
          tx_ctrl[tdu_pkg::CB_PIN] <= 1'b1;
        end else if (!hold_full) begin
          tx_ctrl[tdu_pkg::CB_RUN] <= 1'b0;
        end
      end
    end
  end

  // Receive control register, software then sequencer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ctrl <= '0;
    end else begin
      if (wr && wb_adr_i == tdu_pkg::A_RX_CTRL) begin
        rx_ctrl <= next_rx_ctrl[15:0] & tdu_pkg::CTRL_WMASK &
                   ~(16'h0001 << tdu_pkg::CB_FORCE) &
                   ~(16'h0001 << tdu_pkg::CB_LOAD);
      end
      if (rx_st == RX_IDLE && tx_st == TX_IDLE && edge_evt) begin
        rx_ctrl[tdu_pkg::CB_RUN] <= 1'b1;
      end else if (rx_st == RX_START && rx_evt && rx_s2) begin
        rx_ctrl[tdu_pkg::CB_RUN] <= 1'b0;
      end else if (rx_st == RX_DATA && rx_evt && rx_cnt == tdu_pkg::RX_LAST) begin
        rx_ctrl[tdu_pkg::CB_RUN] <= 1'b0;
      end
    end
  end

  // Transmit holding word, one queued behind the shifter
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_hold   <= '0;
      hold_full <= 1'b0;
    end else if (wr && wb_adr_i == tdu_pkg::A_TX_DATA && !hold_full && wb_sel_i[0]) begin
      tx_hold   <= wb_dat_i[7:0];
      hold_full <= 1'b1;
    end else if (tx_start || (tx_st == TX_RUN && tx_evt && tx_idx == tdu_pkg::TX_END_IDX)) begin
      hold_full <= 1'b0;
    end
  end

  // Transmit bit sequencer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st  <= TX_IDLE;
      tx_idx <= '0;
      tx_sh  <= '0;
    end else begin
      case (tx_st)
        TX_IDLE: begin
          if (tx_start) begin
            tx_st  <= TX_RUN;
            tx_idx <= '0;
            tx_sh  <= tx_hold;
          end
        end
        TX_RUN: begin
          if (tx_evt) begin
            if (tx_idx == tdu_pkg::TX_END_IDX) begin
              if (hold_full) begin
                tx_idx <= '0;
                tx_sh  <= tx_hold;
              end else begin
                tx_st <= TX_IDLE;
              end
            end else begin
              tx_idx <= tx_idx + 4'h1;
              if (tx_idx != '0) begin
                tx_sh <= tx_sh >> 1;
              end
            end
          end
        end
        default: tx_st <= TX_IDLE;
      endcase
    end
  end

  // Receive sequencer: confirm start, gather eight bits
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st  <= RX_IDLE;
      rx_cnt <= '0;
      rx_sh  <= '0;
    end else begin
      case (rx_st)
        RX_IDLE: begin
          if (edge_evt && tx_st == TX_IDLE) begin
            rx_st <= RX_START;
          end
        end
        RX_START: begin
          if (rx_evt) begin
            rx_st  <= rx_s2 ? RX_IDLE : RX_DATA;
            rx_cnt <= '0;
          end
        end
        RX_DATA: begin
          if (rx_evt) begin
            rx_sh  <= {rx_s2, rx_sh[7:1]};
            rx_cnt <= rx_cnt + 3'h1;
            if (rx_cnt == tdu_pkg::RX_LAST) begin
              rx_st <= RX_IDLE;
            end
          end
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // Received byte and full flag, set wins over read clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_byte <= '0;
      rx_full <= 1'b0;
    end else if (rx_st == RX_DATA && rx_evt && rx_cnt == tdu_pkg::RX_LAST) begin
      rx_byte <= {rx_s2, rx_sh[7:1]};
      rx_full <= 1'b1;
    end else if (rd && wb_adr_i == tdu_pkg::A_RX_DATA) begin
      rx_full <= 1'b0;
    end
  end

  // Transmit pin drive: general-purpose or waveform
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_pin_o  <= 1'b1;
      tx_pin_oe <= 1'b0;
    end else if (tx_ctrl[tdu_pkg::CB_MODE]) begin
      tx_pin_o  <= tx_wave ^ tx_ctrl[tdu_pkg::CB_INV];
      tx_pin_oe <= 1'b1;
    end else begin
      tx_pin_o  <= tx_ctrl[tdu_pkg::CB_PIN];
      tx_pin_oe <= tx_ctrl[tdu_pkg::CB_DIR];
    end
  end

  ack_one_a: assert property (@(posedge mclk) disable iff (!rst_n)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  half_duplex_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !(tx_st == TX_RUN && rx_st != RX_IDLE)) else $error("tx and rx both active");
  start_bit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (tx_st == TX_RUN && tx_evt && tx_idx == '0) |=> !tx_ctrl[tdu_pkg::CB_PIN])
    else $error("start bit not low");
  stop_bit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (tx_st == TX_RUN && tx_evt && tx_idx == tdu_pkg::TX_STOP_IDX) |=> ##1 tx_pin_o)
    else $error("stop bit not high on pin");
  rx_reject_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rx_st == RX_START && rx_evt && rx_s2) |=> rx_st == RX_IDLE && !$rose(rx_full))
    else $error("false start accepted");
  rx_deliver_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rx_st == RX_DATA && rx_evt && rx_cnt == tdu_pkg::RX_LAST) |=>
    rx_full && !rx_ctrl[tdu_pkg::CB_RUN] && rx_st == RX_IDLE)
    else $error("byte not delivered");
  chain_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!int_ctrl[tdu_pkg::IC_EE] && !tx_start) |=> $stable(tx_idx) && $stable(rx_cnt))
    else $error("sequencer moved without enable");
  tx_finish_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (tx_st == TX_RUN && tx_evt && tx_idx == tdu_pkg::TX_END_IDX && !hold_full) |=>
    !tx_ctrl[tdu_pkg::CB_RUN] && tx_st == TX_IDLE) else $error("timer not stopped");
endmodule
`default_nettype wire

//--- tdu_peer.sv
// Remote serial partner: frame receiver and frame sender
`timescale 1ns/1ps
`default_nettype none
module tdu_peer (
  input  wire logic mclk,
  input  wire logic line,
  output logic      rxd
);
  int         bitc = 32;
  logic [7:0] got[$];
  logic [7:0] sh;

  initial rxd = 1'b1;

  // Frame capture: start confirmed mid-bit, data LSB first
  always begin
    @(negedge line);
    repeat (bitc / 2) @(posedge mclk);
    if (line === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (bitc) @(posedge mclk);
        sh[i] = line;
      end
      repeat (bitc) @(posedge mclk);
      got.push_back(sh);
    end
  end

  // Frame sender at the agreed bit time, idles high
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      rxd <= f[i];
      repeat (bitc - 1) @(posedge mclk);
    end
  endtask

  // Short low pulse that must not pass for a start bit
  task automatic glitch(input int n);
    @(posedge mclk);
    rxd <= 1'b0;
    repeat (n) @(posedge mclk);
    rxd <= 1'b1;
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the timer-paced serial block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk = 1'b0;
  logic        rst_n, cyc, stb, we, doze;
  logic [31:0] adr, wdat, q, wb_dat_o;
  logic        wb_ack_o, tx_pin_o, tx_pin_oe, rxd;
  logic [7:0]  b, b2;
  int          n_fail = 0;
  int          checked = 0;
  int          cycles = 0;
  int          seed = 81947;
  int          lows;
  wire         tx_line = tx_pin_oe ? tx_pin_o : 1'b1;

  always #50 mclk = ~mclk;

  tdu_uart DUT (.mclk(mclk), .rst_n(rst_n), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .doze(doze), .tx_pin_i(tx_line),
    .tx_pin_o(tx_pin_o), .tx_pin_oe(tx_pin_oe), .rx_edge_i(rxd));

  tdu_peer peer (.mclk(mclk), .line(tx_line), .rxd(rxd));

  task automatic end_of_test;
    if (n_fail == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic single Wishbone access, waits for ack
  task automatic acc(input logic [31:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    adr <= a;
    we <= w;
    wdat <= d;
    cyc <= 1'b1;
    stb <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
      n_fail++;
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // Send one byte and wait for the partner to capture it
  task automatic tx_byte(input logic [7:0] v);
    int n;
    n = peer.got.size();
    acc(tdu_pkg::A_TX_DATA, 1'b1, {24'h0000_00, v});
    for (int i = 0; i < 2000 && peer.got.size() <= n; i++)
      @(posedge mclk);
    chk(peer.got.size() > n ? peer.got[n] : 8'hxx, v);
    // Let the stop bit finish so the transmitter is idle again
    repeat (peer.bitc) @(posedge mclk);
  endtask

  // Poll received byte and compare
  task automatic rx_chk(input logic [7:0] v);
    for (int i = 0; i < 60; i++) begin
      acc(tdu_pkg::A_RX_DATA, 1'b0, 32'h0000_0000);
      if (q[8] === 1'b1)
        break;
    end
    chk(q[8:0], {1'b1, v});
  endtask

  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    doze = 1'b0;
    adr = 32'h0000_0000;
    wdat = 32'h0000_0000;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk(tx_pin_o, 1'b1);
    chk(tx_pin_oe, 1'b0);
    acc(tdu_pkg::A_TX_CTRL, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0080);
    acc(32'h1000_5040, 1'b0, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    // Enable chain through the fast path, bit times
    acc(tdu_pkg::A_INT_CTRL, 1'b1, 32'h0000_000d);
    acc(tdu_pkg::A_INT_MASK, 1'b1, 32'hc040_0000);
    acc(tdu_pkg::A_TX_PER, 1'b1, 32'h0000_0008);
    acc(tdu_pkg::A_RX_PER, 1'b1, 32'h0000_0008);
    acc(tdu_pkg::A_RX_CTRL, 1'b1, 32'h0000_0200);
    // Transmit at two prescale codes, corner and random bytes
    for (int p = 1; p >= 0; p--) begin
      peer.bitc = 8 * (4 << p);
      acc(tdu_pkg::A_TX_CTRL, 1'b1, 32'h0000_02c0 | p);
      @(posedge mclk);
      chk(tx_pin_oe, 1'b1);
      tx_byte(p ? 8'h00 : 8'hff);
      b = 8'($random(seed));
      tx_byte(b);
    end
    // Two queued words sent back to back, then timer stops
    b = 8'($random(seed));
    b2 = 8'($random(seed));
    lows = peer.got.size();
    acc(tdu_pkg::A_TX_DATA, 1'b1, {24'h0000_00, b});
    repeat (4) @(posedge mclk);
    acc(tdu_pkg::A_TX_DATA, 1'b1, {24'h0000_00, b2});
    for (int i = 0; i < 3000 && peer.got.size() < lows + 2; i++)
      @(posedge mclk);
    chk(peer.got.size() > lows ? peer.got[lows] : 8'hxx, b);
    chk(peer.got.size() > lows + 1 ? peer.got[lows + 1] : 8'hxx, b2);
    repeat (60) @(posedge mclk);
    acc(tdu_pkg::A_TX_CTRL, 1'b0, 32'h0000_0000);
    chk(q[7:0] & 8'h88, 8'h80);
    // Reception of random bytes, read clears ready
    for (int k = 0; k < 3; k++) begin
      b = 8'($random(seed));
      peer.send(b);
      rx_chk(b);
      acc(tdu_pkg::A_RX_DATA, 1'b0, 32'h0000_0000);
      chk(q[8], 1'b0);
    end
    // Short low pulse is rejected at mid start bit
    peer.glitch(4);
    repeat (400) @(posedge mclk);
    acc(tdu_pkg::A_RX_DATA, 1'b0, 32'h0000_0000);
    chk(q[8], 1'b0);
    // Transmit queued during reception waits for it
    b = 8'($random(seed));
    b2 = 8'($random(seed));
    lows = peer.got.size();
    fork
      peer.send(b);
    join_none
    repeat (40) @(posedge mclk);
    acc(tdu_pkg::A_TX_DATA, 1'b1, {24'h0000_00, b2});
    acc(tdu_pkg::A_TX_DATA, 1'b0, 32'h0000_0000);
    chk(q[2:1], 2'b11);
    for (int i = 0; i < 180; i++) begin
      @(posedge mclk);
      chk(tx_pin_o, 1'b1);
      if (tx_pin_o !== 1'b1)
        break;
    end
    rx_chk(b);
    for (int i = 0; i < 2000 && peer.got.size() <= lows; i++)
      @(posedge mclk);
    chk(peer.got.size() > lows ? peer.got[lows] : 8'hxx, b2);
    // Doze with the halt bit set freezes the transmit timer
    repeat (40) @(posedge mclk);
    doze <= 1'b1;
    acc(tdu_pkg::A_TX_CTRL, 1'b1, 32'h0000_0ac0);
    lows = peer.got.size();
    acc(tdu_pkg::A_TX_DATA, 1'b1, {24'h0000_00, b});
    repeat (200) @(posedge mclk);
    chk(tx_pin_o, 1'b1);
    doze <= 1'b0;
    for (int i = 0; i < 2000 && peer.got.size() <= lows; i++)
      @(posedge mclk);
    chk(peer.got.size() > lows ? peer.got[lows] : 8'hxx, b);
    end_of_test();
  end
endmodule
`default_nettype wire
